// ==== sevg_params.svh ====
// Offsets, codes and layout constants for the system event vector generator
`ifndef SEVG_PARAMS_SVH
`define SEVG_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SEVG_OFF_USER_NMI_VECTOR 9'h19A
`define SEVG_OFF_SYSTEM_NMI_VECTOR 9'h19C
`define SEVG_OFF_RESET_CAUSE_VECTOR 9'h19E
`define SEVG_OFF_IRQ_STATUS 9'h1A0
`define SEVG_OFF_IRQ_ENABLE 9'h1A2
`define SEVG_OFF_IRQ_CLEAR 9'h1A4

// ****************************************
// Widths and reset values
// ****************************************
`define SEVG_ADDR_W 9
`define SEVG_DATA_W 16
`define SEVG_RST_SRC_N 23
`define SEVG_SNMI_SRC_N 12
`define SEVG_UNMI_SRC_N 2
`define SEVG_NONE_CODE 16'h0000
`define SEVG_IRQ_ENABLE_RST 3'h0

// ****************************************
// Interrupt status bit positions
// ****************************************
`define SEVG_IRQ_RST_BIT 0
`define SEVG_IRQ_SNMI_BIT 1
`define SEVG_IRQ_UNMI_BIT 2

// ****************************************
// Reset class encodings
// ****************************************
`define SEVG_CLASS_NONE 2'h0
`define SEVG_CLASS_BOR 2'h1
`define SEVG_CLASS_POR 2'h2
`define SEVG_CLASS_PUC 2'h3

`endif

// ==== sevg_pkg.sv ====
// Types shared by the system event vector generator
package sevg_pkg;

  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sevg_bus_req_t;

  // Reset event sources, lowest index = highest priority
  typedef struct packed {
    logic seg_three_violation_flag;
    logic seg_two_violation_flag;
    logic seg_one_violation_flag;
    logic info_segment_violation_flag;
    logic ip_segment_violation_flag;
    logic clock_system_key_violation;
    logic protection_unit_key_violation;
    logic power_mgmt_key_violation;
    logic periph_area_fetch;
    logic fram_uncorrectable;
    logic fram_ctrl_key_violation;
    logic watchdog_key_violation;
    logic watchdog_expiry_flag;
    logic software_poweron_request;
    logic rsv_12;
    logic rsv_10;
    logic high_supply_supervisor_flag;
    logic rsv_0c;
    logic security_violation;
    logic deep_lpm_wakeup;
    logic software_brownout_request;
    logic reset_pin_flag;
    logic brownout;
  } sevg_rst_src_t;

  typedef struct packed {
    logic fram_correctable;
    logic debug_mailbox_out_flag;
    logic debug_mailbox_in_flag;
    logic vacant_access_flag;
    logic seg_three_violation_flag;
    logic seg_two_violation_flag;
    logic seg_one_violation_flag;
    logic info_segment_violation_flag;
    logic ip_segment_violation_flag;
    logic access_time_error_flag;
    logic fram_uncorrectable;
    logic supervisor_lp_reset_entry;
  } sevg_snmi_src_t;

  typedef struct packed {
    logic oscillator_fault_flag;
    logic nmi_pin_flag;
  } sevg_unmi_src_t;

endpackage

// ==== sevg_top.sv ====
// System event vector generator: reset, system NMI and user NMI vectors
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "sevg_params.svh"

// Notes on behaviour
// R1: Reset vector reads 02h brownout, 04h reset pin, 06h software brownout, all brownout-level.
// R2: Reset vector reads 08h deep low-power wakeup, 0Ah security, 0Eh high-side supervisor; 0Ch,10h,12h reserved.
// R3: A software power-on request reads 14h and is power-on-level.
// R4: Watchdog expiry reads 16h and bad watchdog key 18h, both power-up-clear-level.
// R5: FRAM control key violation reads 1Ah and uncorrectable FRAM error 1Ch, both power-up-clear-level.
// R6: An instruction fetch from the peripheral area reads 1Eh, power-up-clear-level.
// R7: Power, protection-unit and clock key violations read 20h, 22h, 24h, power-up-clear-level.
// R8: Segment violations set to reset read 26h IP, 28h info, 2Ah/2Ch/2Eh segments 1 to 3.
// R9: Each vector reads the highest-priority pending code, lower code first, 00h when idle.
// R10: System NMI reads 02h supervisor low-power entry, 04h uncorrectable FRAM, 06h access time.
// R11: Segment violations to system NMI read 08h IP, 0Ah info, 0Ch/0Eh/10h segments 1 to 3.
// R12: A vacant memory access reads system NMI code 12h.
// R13: Mailbox input written reads 14h, mailbox output event 16h.
// R14: Correctable FRAM error reads 18h, the lowest source; 1Ah to 1Eh reserved.
// R15: User NMI reads 02h for the NMI pin, highest, and 04h for oscillator fault.
// R16: Reading a vector clears the flag of the code it returned.
module sevg_top #(
  parameter int RST_N = `SEVG_RST_SRC_N,
  parameter int SNMI_N = `SEVG_SNMI_SRC_N,
  parameter int UNMI_N = `SEVG_UNMI_SRC_N
) (
  input wire logic clk_sys_i, // 200 MHz system clock
  input wire logic reset_i, // Sync active-high reset
  input wire sevg_pkg::sevg_bus_req_t bus_i, // Register bus request
  input wire sevg_pkg::sevg_rst_src_t rst_evt_i, // Reset event pulses
  input wire sevg_pkg::sevg_snmi_src_t snmi_evt_i, // System NMI event pulses
  input wire sevg_pkg::sevg_unmi_src_t unmi_evt_i, // User NMI event pulses
  output logic [15:0] rdata_o, // Read data, cycle after rd
  output logic [1:0] rst_class_o, // Class of pending top reset
  output logic snmi_pend_o, // System NMI pending
  output logic unmi_pend_o, // User NMI pending
  output logic irq_o // Level interrupt
);
  import sevg_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Lowest set index wins; code = 2*(index+1), zero when idle
  function automatic logic [15:0] prio_code(input logic [31:0] flags);
    logic [15:0] c;
    c = `SEVG_NONE_CODE;
    for (int i = 31; i >= 0; i--) begin
      if (flags[i]) begin
        c = 16'((i + 1) * 2);
      end
    end
    return c;
  endfunction

  // One-hot mask of the flag that a code names
  function automatic logic [31:0] code_mask(input logic [15:0] code);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (code != `SEVG_NONE_CODE) begin
      m[5'((code >> 1) - 16'h0001)] = 1'b1;
    end
    return m;
  endfunction

  // ****************************************
  // Flags and decode
  // ****************************************
  logic [RST_N-1:0] rst_flag_r;
  logic [RST_N-1:0] rst_flag_nxt;
  logic [SNMI_N-1:0] snmi_flag_r;
  logic [SNMI_N-1:0] snmi_flag_nxt;
  logic [UNMI_N-1:0] unmi_flag_r;
  logic [UNMI_N-1:0] unmi_flag_nxt;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_stat_nxt;
  logic [2:0] irq_en_r;

  wire [31:0] rst_flag_w = 32'(rst_flag_r);
  wire [31:0] snmi_flag_w = 32'(snmi_flag_r);
  wire [31:0] unmi_flag_w = 32'(unmi_flag_r);
  // Reserved reset slots are never set
  wire [RST_N-1:0] rst_evt_w = rst_evt_i & ~(RST_N'(23'h0001A0)); // R2

  wire [15:0] rst_code_w = prio_code(rst_flag_w); // R1 R2 R3 R4 R5 R6 R7 R8 R9
  wire [15:0] snmi_code_w = prio_code(snmi_flag_w); // R9 R10 R11 R12 R13 R14
  wire [15:0] unmi_code_w = prio_code(unmi_flag_w); // R9 R15

  wire rd_rst_w = bus_i.rd && bus_i.addr == `SEVG_OFF_RESET_CAUSE_VECTOR;
  wire rd_snmi_w = bus_i.rd && bus_i.addr == `SEVG_OFF_SYSTEM_NMI_VECTOR;
  wire rd_unmi_w = bus_i.rd && bus_i.addr == `SEVG_OFF_USER_NMI_VECTOR;
  wire rd_stat_w = bus_i.rd && bus_i.addr == `SEVG_OFF_IRQ_STATUS;
  wire rd_en_w = bus_i.rd && bus_i.addr == `SEVG_OFF_IRQ_ENABLE;
  wire wr_en_w = bus_i.wr && bus_i.addr == `SEVG_OFF_IRQ_ENABLE;
  wire wr_clr_w = bus_i.wr && bus_i.addr == `SEVG_OFF_IRQ_CLEAR;

  // Read-to-clear only drops the reported flag; a new event still sets
  wire [RST_N-1:0] rst_clr_w = rd_rst_w ? RST_N'(code_mask(rst_code_w)) : '0; // R16
  wire [SNMI_N-1:0] snmi_clr_w = rd_snmi_w ? SNMI_N'(code_mask(snmi_code_w)) : '0; // R16
  wire [UNMI_N-1:0] unmi_clr_w = rd_unmi_w ? UNMI_N'(code_mask(unmi_code_w)) : '0; // R16

  assign rst_flag_nxt = (rst_flag_r & ~rst_clr_w) | rst_evt_w;
  assign snmi_flag_nxt = (snmi_flag_r & ~snmi_clr_w) | SNMI_N'(snmi_evt_i);
  assign unmi_flag_nxt = (unmi_flag_r & ~unmi_clr_w) | UNMI_N'(unmi_evt_i);

  wire [2:0] irq_evt_w = {|unmi_evt_i, |snmi_evt_i, |rst_evt_w};
  wire [2:0] irq_clr_w = wr_clr_w ? bus_i.wdata[2:0] : 3'h0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | irq_evt_w;

  // Class of the top reset cause
  wire [4:0] rst_idx_w = 5'((rst_code_w >> 1) - 16'h0001);
  wire [1:0] rst_class_w = (rst_code_w == `SEVG_NONE_CODE) ? `SEVG_CLASS_NONE :
    (rst_idx_w <= 5'h07) ? `SEVG_CLASS_BOR : // R1 R2
    (rst_idx_w == 5'h09) ? `SEVG_CLASS_POR : `SEVG_CLASS_PUC; // R3 R4 R5 R6 R7 R8

  wire [15:0] rdata_w = rd_rst_w ? rst_code_w :
    rd_snmi_w ? snmi_code_w :
    rd_unmi_w ? unmi_code_w :
    rd_stat_w ? {13'h0000, irq_stat_r} :
    rd_en_w ? {13'h0000, irq_en_r} : 16'h0000;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rst_flag_r <= '0;
      snmi_flag_r <= '0;
      unmi_flag_r <= '0;
      irq_stat_r <= 3'h0;
      irq_en_r <= `SEVG_IRQ_ENABLE_RST;
    end else begin
      rst_flag_r <= rst_flag_nxt;
      snmi_flag_r <= snmi_flag_nxt;
      unmi_flag_r <= unmi_flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      if (wr_en_w) begin
        irq_en_r <= bus_i.wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
      rst_class_o <= `SEVG_CLASS_NONE;
      snmi_pend_o <= 1'b0;
      unmi_pend_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= rdata_w;
      rst_class_o <= rst_class_w;
      snmi_pend_o <= |snmi_flag_r;
      unmi_pend_o <= |unmi_flag_r;
      irq_o <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_idle_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r == '0) |=> rdata_o == 16'h0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle reset vector not zero"); // R9

  property p_brownout_top;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[0]) |=> rdata_o == 16'h0002;
  endproperty
  a_brownout_top: assert property (p_brownout_top) else $error("brownout not reported first"); // R1

  property p_pin_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[1:0] == 2'b10) |=> rdata_o == 16'h0004;
  endproperty
  a_pin_code: assert property (p_pin_code) else $error("reset pin code wrong"); // R1

  property p_reserved_never;
    @(posedge clk_sys_i) disable iff (reset_i)
      rst_flag_r[5] == 1'b0 && rst_flag_r[7] == 1'b0 && rst_flag_r[8] == 1'b0;
  endproperty
  a_reserved_never: assert property (p_reserved_never) else $error("reserved reset slot set"); // R2

  property p_por_class;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rst_flag_r[8:0] == '0 && rst_flag_r[9]) |=> rst_class_o == `SEVG_CLASS_POR;
  endproperty
  a_por_class: assert property (p_por_class) else $error("software POR class wrong"); // R3

  property p_wdt_class;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rst_flag_r[9:0] == '0 && rst_flag_r[10]) |=> rst_class_o == `SEVG_CLASS_PUC;
  endproperty
  a_wdt_class: assert property (p_wdt_class) else $error("watchdog class wrong"); // R4

  property p_seg3_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r == RST_N'(23'h400000)) |=> rdata_o == 16'h002E;
  endproperty
  a_seg3_code: assert property (p_seg3_code) else $error("segment 3 reset code wrong"); // R8

  property p_snmi_low;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r == SNMI_N'(12'h800)) |=> rdata_o == 16'h0018;
  endproperty
  a_snmi_low: assert property (p_snmi_low) else $error("correctable FRAM code wrong"); // R14

  property p_vacant;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r == SNMI_N'(12'h100)) |=> rdata_o == 16'h0012;
  endproperty
  a_vacant: assert property (p_vacant) else $error("vacant access code wrong"); // R12

  property p_unmi_pin;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_unmi_w && unmi_flag_r[0]) |=> rdata_o == 16'h0002;
  endproperty
  a_unmi_pin: assert property (p_unmi_pin) else $error("NMI pin code wrong"); // R15

  sequence s_read_top;
    rd_unmi_w && unmi_flag_r == 2'b11 && unmi_evt_i == '0;
  endsequence
  property p_read_clears;
    @(posedge clk_sys_i) disable iff (reset_i)
      s_read_top |=> unmi_flag_r == 2'b10;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear top flag"); // R16

  // ****************************************
  // Per-source codes and classes, and reset read-to-clear
  // ****************************************
  // Higher-priority flags are clear in each antecedent, so the checks hold with others pending
  property p_bor_class;
    @(posedge clk_sys_i) disable iff (reset_i)
      rst_flag_r[0] |=> rst_class_o == `SEVG_CLASS_BOR;
  endproperty
  a_bor_class: assert property (p_bor_class) else $error("brownout class wrong"); // R1

  property p_swbor_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[1:0] == '0 && rst_flag_r[2]) |=> rdata_o == 16'h0006;
  endproperty
  a_swbor_code: assert property (p_swbor_code) else $error("software brownout code wrong"); // R1

  property p_security_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[3:0] == '0 && rst_flag_r[4]) |=> rdata_o == 16'h000A;
  endproperty
  a_security_code: assert property (p_security_code) else $error("security code wrong"); // R2

  property p_supervisor_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[5:0] == '0 && rst_flag_r[6]) |=> rdata_o == 16'h000E;
  endproperty
  a_supervisor_code: assert property (p_supervisor_code) else $error("supervisor code wrong"); // R2

  property p_por_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[8:0] == '0 && rst_flag_r[9]) |=> rdata_o == 16'h0014;
  endproperty
  a_por_code: assert property (p_por_code) else $error("software power-on code wrong"); // R3

  property p_wdt_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[9:0] == '0 && rst_flag_r[10]) |=> rdata_o == 16'h0016;
  endproperty
  a_wdt_code: assert property (p_wdt_code) else $error("watchdog expiry code wrong"); // R4

  property p_wdt_key_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[10:0] == '0 && rst_flag_r[11]) |=> rdata_o == 16'h0018;
  endproperty
  a_wdt_key_code: assert property (p_wdt_key_code) else $error("watchdog key code wrong"); // R4

  property p_fram_err_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[12:0] == '0 && rst_flag_r[13]) |=> rdata_o == 16'h001C;
  endproperty
  a_fram_err_code: assert property (p_fram_err_code) else $error("FRAM error code wrong"); // R5

  property p_fetch_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[13:0] == '0 && rst_flag_r[14]) |=> rdata_o == 16'h001E;
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("peripheral fetch code wrong"); // R6

  property p_fetch_class;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rst_flag_r[13:0] == '0 && rst_flag_r[14]) |=> rst_class_o == `SEVG_CLASS_PUC;
  endproperty
  a_fetch_class: assert property (p_fetch_class) else $error("peripheral fetch class wrong"); // R6

  property p_pmm_key_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[14:0] == '0 && rst_flag_r[15]) |=> rdata_o == 16'h0020;
  endproperty
  a_pmm_key_code: assert property (p_pmm_key_code) else $error("power key code wrong"); // R7

  property p_cs_key_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[16:0] == '0 && rst_flag_r[17]) |=> rdata_o == 16'h0024;
  endproperty
  a_cs_key_code: assert property (p_cs_key_code) else $error("clock key code wrong"); // R7

  property p_ip_seg_code;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[17:0] == '0 && rst_flag_r[18]) |=> rdata_o == 16'h0026;
  endproperty
  a_ip_seg_code: assert property (p_ip_seg_code) else $error("IP segment reset code wrong"); // R8

  property p_snmi_top;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r[0]) |=> rdata_o == 16'h0002;
  endproperty
  a_snmi_top: assert property (p_snmi_top) else $error("supervisor entry code wrong"); // R10

  property p_access_time;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r[1:0] == '0 && snmi_flag_r[2]) |=> rdata_o == 16'h0006;
  endproperty
  a_access_time: assert property (p_access_time) else $error("access time code wrong"); // R10

  property p_snmi_ip_seg;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r[2:0] == '0 && snmi_flag_r[3]) |=> rdata_o == 16'h0008;
  endproperty
  a_snmi_ip_seg: assert property (p_snmi_ip_seg) else $error("IP segment NMI code wrong"); // R11

  property p_mailbox_in;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r[8:0] == '0 && snmi_flag_r[9]) |=> rdata_o == 16'h0014;
  endproperty
  a_mailbox_in: assert property (p_mailbox_in) else $error("mailbox input code wrong"); // R13

  property p_mailbox_out;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_snmi_w && snmi_flag_r[9:0] == '0 && snmi_flag_r[10]) |=> rdata_o == 16'h0016;
  endproperty
  a_mailbox_out: assert property (p_mailbox_out) else $error("mailbox output code wrong"); // R13

  property p_osc_fault;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_unmi_w && unmi_flag_r == 2'b10) |=> rdata_o == 16'h0004;
  endproperty
  a_osc_fault: assert property (p_osc_fault) else $error("oscillator fault code wrong"); // R15

  property p_rst_read_clears;
    @(posedge clk_sys_i) disable iff (reset_i)
      (rd_rst_w && rst_flag_r[1:0] == 2'b11 && !rst_evt_w[0]) |=> rst_flag_r[1:0] == 2'b10;
  endproperty
  a_rst_read_clears: assert property (p_rst_read_clears) else $error("reset read did not clear"); // R16

endmodule

// ==== sevg_evt_model.sv ====
// Event source model driving the generator's event inputs
`timescale 1ns/1ps
module sevg_evt_model (
  input wire logic clk_sys_i, // System clock
  input wire logic [22:0] rst_fire_i, // Reset sources to pulse
  input wire logic [11:0] snmi_fire_i, // System NMI sources to pulse
  input wire logic [1:0] unmi_fire_i, // User NMI sources to pulse
  output sevg_pkg::sevg_rst_src_t rst_evt_o, // Reset event pulses
  output sevg_pkg::sevg_snmi_src_t snmi_evt_o, // System NMI event pulses
  output sevg_pkg::sevg_unmi_src_t unmi_evt_o // User NMI event pulses
);
  import sevg_pkg::*;
  // ****
  // Pulse launch
  // ****
  // Launched just after the edge, as real flag logic would, so no race at the sampling edge
  always @(posedge clk_sys_i) begin
    rst_evt_o <= rst_fire_i;
    snmi_evt_o <= snmi_fire_i;
    unmi_evt_o <= unmi_fire_i;
  end
endmodule

// ==== tb_system_event_vector_generator.sv ====
// Self-checking bench for the system event vector generator
`timescale 1ns/1ps
`include "sevg_params.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp); end end
module tb_system_event_vector_generator;
  import sevg_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  sevg_bus_req_t bus_i = '0;
  logic [22:0] rst_fire = '0;
  logic [11:0] snmi_fire = '0;
  logic [1:0] unmi_fire = '0;
  sevg_rst_src_t rst_evt;
  sevg_snmi_src_t snmi_evt;
  sevg_unmi_src_t unmi_evt;
  logic [15:0] rdata_o;
  logic [1:0] rst_class_o;
  logic snmi_pend_o;
  logic unmi_pend_o;
  logic irq_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sevg_evt_model i_src (.clk_sys_i(clk_sys_i), .rst_fire_i(rst_fire), .snmi_fire_i(snmi_fire),
    .unmi_fire_i(unmi_fire), .rst_evt_o(rst_evt), .snmi_evt_o(snmi_evt), .unmi_evt_o(unmi_evt));
  sevg_top i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus_i), .rst_evt_i(rst_evt),
    .snmi_evt_i(snmi_evt), .unmi_evt_i(unmi_evt), .rdata_o(rdata_o), .rst_class_o(rst_class_o),
    .snmi_pend_o(snmi_pend_o), .unmi_pend_o(unmi_pend_o), .irq_o(irq_o));

  // ****
  // Bus and event tasks
  // ****
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i.wr <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] exp, input string msg);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i.rd <= 1'b0;
    #1;
    `CHK(rdata_o, exp, msg)
  endtask

  // Flags and pending outputs are settled three edges after the request
  task automatic fire(input logic [22:0] r, input logic [11:0] s, input logic [1:0] u);
    @(posedge clk_sys_i);
    rst_fire <= r;
    snmi_fire <= s;
    unmi_fire <= u;
    @(posedge clk_sys_i);
    rst_fire <= '0;
    snmi_fire <= '0;
    unmi_fire <= '0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  function automatic logic [1:0] cls(input int i);
    if (i == 5 || i == 7 || i == 8) return `SEVG_CLASS_NONE;
    if (i <= 6) return `SEVG_CLASS_BOR;
    if (i == 9) return `SEVG_CLASS_POR;
    return `SEVG_CLASS_PUC;
  endfunction

  // ****
  // Scenarios
  // ****
  task automatic t_idle();
    #1;
    `CHK(rst_class_o, 2'h0, "class idle")
    `CHK(irq_o, 1'b0, "irq idle")
    rd(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'h0000, "rst idle");
    rd(`SEVG_OFF_SYSTEM_NMI_VECTOR, 16'h0000, "snmi idle");
    rd(`SEVG_OFF_USER_NMI_VECTOR, 16'h0000, "unmi idle");
    wr(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'hFFFF);
    rd(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'h0000, "rst ro");
    rd(9'h100, 16'h0000, "unmapped");
    rd(`SEVG_OFF_IRQ_ENABLE, 16'h0000, "enable reset");
    $display("test idle done");
  endtask

  // Each reset source alone, reserved ones included
  task automatic t_rst_each();
    logic [15:0] code;
    for (int i = 0; i < 23; i++) begin
      code = (cls(i) == `SEVG_CLASS_NONE) ? 16'h0000 : 16'(2 * (i + 1));
      fire(23'(1) << i, '0, '0);
      `CHK(rst_class_o, cls(i), "rst class")
      rd(`SEVG_OFF_RESET_CAUSE_VECTOR, code, "rst code");
      rd(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'h0000, "rst cleared");
    end
    $display("test reset sources done");
  endtask

  // All non-reserved sources at once drain in ascending code order
  task automatic t_prio();
    fire(23'h7FFE5F, 12'hFFF, 2'h3);
    `CHK(rst_class_o, `SEVG_CLASS_BOR, "class top")
    `CHK(snmi_pend_o, 1'b1, "snmi pend")
    `CHK(unmi_pend_o, 1'b1, "unmi pend")
    for (int i = 0; i < 23; i++) begin
      if (cls(i) != `SEVG_CLASS_NONE) rd(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'(2 * (i + 1)), "rst prio");
    end
    for (int i = 0; i < 12; i++) rd(`SEVG_OFF_SYSTEM_NMI_VECTOR, 16'(2 * (i + 1)), "snmi prio");
    rd(`SEVG_OFF_USER_NMI_VECTOR, 16'h0002, "unmi pin");
    rd(`SEVG_OFF_USER_NMI_VECTOR, 16'h0004, "unmi osc");
    rd(`SEVG_OFF_RESET_CAUSE_VECTOR, 16'h0000, "rst empty");
    rd(`SEVG_OFF_SYSTEM_NMI_VECTOR, 16'h0000, "snmi empty");
    rd(`SEVG_OFF_USER_NMI_VECTOR, 16'h0000, "unmi empty");
    @(posedge clk_sys_i);
    #1;
    `CHK(snmi_pend_o, 1'b0, "snmi drained")
    `CHK(unmi_pend_o, 1'b0, "unmi drained")
    $display("test priority done");
  endtask

  task automatic t_snmi_each();
    for (int i = 0; i < 12; i++) begin
      fire('0, 12'(1) << i, '0);
      rd(`SEVG_OFF_SYSTEM_NMI_VECTOR, 16'(2 * (i + 1)), "snmi code");
    end
    $display("test system nmi done");
  endtask

  task automatic t_irq();
    wr(`SEVG_OFF_IRQ_CLEAR, 16'h0007);
    rd(`SEVG_OFF_IRQ_STATUS, 16'h0000, "status clear");
    fire(23'h000001, 12'h001, 2'h2);
    `CHK(irq_o, 1'b0, "irq masked")
    rd(`SEVG_OFF_IRQ_STATUS, 16'h0007, "status set");
    wr(`SEVG_OFF_IRQ_ENABLE, 16'h0002);
    `CHK(irq_o, 1'b1, "irq on")
    rd(`SEVG_OFF_IRQ_ENABLE, 16'h0002, "enable rb");
    wr(`SEVG_OFF_IRQ_CLEAR, 16'h0002);
    `CHK(irq_o, 1'b0, "irq cleared")
    rd(`SEVG_OFF_IRQ_STATUS, 16'h0005, "status partial");
    $display("test interrupt done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_idle();
    t_rst_each();
    t_snmi_each();
    t_prio();
    t_irq();
    end_sim();
  end
endmodule
